// >>> rtl/alu_subset_pkg.sv
// Package with constants, operation codes and the behaviour list of the instruction-subset datapath.
// Behaviour
// [RL1] Halt clears watchdog counter and its prescaler.
// [RL2] Halt clears power_down_flag, sets expiry_flag only.
// [RL3] After halt, sleep with oscillator stopped.
// [RL4] Literal minus accumulator into accumulator; C, DC, Z.
// [RL5] Rotate file right through carry; only carry.
// [RL6] File minus accumulator; C, DC, Z updated.
// [RL7] Destination bit 0 accumulator, 1 file.
// [RL8] Swap file nibbles to destination; no flags.
// [RL9] Literal xor accumulator into accumulator; only Z.
// [RL10] File xor accumulator to destination; only Z.
// [RL11] Zero flag set when result equals zero.
package alu_subset_pkg;
    localparam int DATA_WIDTH = 8;
    localparam int ADDR_WIDTH = 7;
    localparam int WDT_WIDTH = 8;
    localparam int PRESCALE_WIDTH = 8;
    localparam logic [7:0] WDT_CLEAR_VALUE = 8'h00;
    localparam logic [7:0] PRESCALE_CLEAR_VALUE = 8'h00;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam int STATUS_CARRY_BIT = 0;
    localparam int STATUS_HALF_BIT = 1;
    localparam int STATUS_ZERO_BIT = 2;
    localparam int STATUS_POWER_DOWN_BIT = 3;
    localparam int STATUS_EXPIRY_BIT = 4;
    localparam logic [4:0] STATUS_RESET = 5'h18;
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;

    typedef enum logic [2:0] {
        OP_NONE = 3'h0,
        OP_HALT = 3'h1,
        OP_LIT_MINUS_ACC = 3'h2,
        OP_ROTATE_RIGHT_CARRY = 3'h3,
        OP_FILE_MINUS_ACC = 3'h4,
        OP_NIBBLE_EXCHANGE = 3'h5,
        OP_XOR_LIT_ACC = 3'h6,
        OP_XOR_FILE_ACC = 3'h7
    } op_type;

    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_SLEEP = 2'b10
    } power_state_type;
endpackage

// >>> rtl/alu_result_unit.sv
// Combinational result and flag unit for the instruction subset.
`timescale 1ns/1ps
module alu_result_unit #(
    parameter int WIDTH = 8
) (
    // Operation and operands.
    input wire alu_subset_pkg::op_type op_i,
    input wire logic [WIDTH-1:0] acc_i,
    input wire logic [WIDTH-1:0] file_i,
    input wire logic [WIDTH-1:0] literal_i,
    input wire logic carry_i,
    // Result and flags.
    output logic [WIDTH-1:0] result_o,
    output logic carry_o,
    output logic half_o,
    output logic zero_o,
    output logic carry_we_o,
    output logic half_we_o,
    output logic zero_we_o
);
    logic [WIDTH-1:0] minuend;
    logic [WIDTH:0] diff;
    logic [4:0] low_diff;

    always_comb begin
        minuend = (op_i == alu_subset_pkg::OP_LIT_MINUS_ACC) ? literal_i : file_i;
        // Two's complement subtraction: carry is set when no borrow occurs.
        diff = {1'b0, minuend} + {1'b0, ~acc_i} + {{WIDTH{1'b0}}, 1'b1}; // [RL4] [RL6]
        low_diff = {1'b0, minuend[3:0]} + {1'b0, ~acc_i[3:0]} + 5'h01;
        result_o = acc_i;
        carry_o = carry_i;
        half_o = 1'b0;
        carry_we_o = 1'b0;
        half_we_o = 1'b0;
        zero_we_o = 1'b0;
        unique case (op_i)
            alu_subset_pkg::OP_LIT_MINUS_ACC, alu_subset_pkg::OP_FILE_MINUS_ACC: begin
                result_o = diff[WIDTH-1:0]; // [RL4] [RL6]
                carry_o = diff[WIDTH];
                half_o = low_diff[4];
                carry_we_o = 1'b1;
                half_we_o = 1'b1;
                zero_we_o = 1'b1;
            end
            alu_subset_pkg::OP_ROTATE_RIGHT_CARRY: begin
                result_o = {carry_i, file_i[WIDTH-1:1]}; // [RL5]
                carry_o = file_i[0];
                carry_we_o = 1'b1;
            end
            alu_subset_pkg::OP_NIBBLE_EXCHANGE: begin
                result_o = {file_i[3:0], file_i[7:4]}; // [RL8]
            end
            alu_subset_pkg::OP_XOR_LIT_ACC: begin
                result_o = acc_i ^ literal_i; // [RL9]
                zero_we_o = 1'b1;
            end
            alu_subset_pkg::OP_XOR_FILE_ACC: begin
                result_o = acc_i ^ file_i; // [RL10]
                zero_we_o = 1'b1;
            end
            default: begin
                result_o = acc_i;
            end
        endcase
        zero_o = (result_o == alu_subset_pkg::ZERO_BYTE); // [RL11]
    end
endmodule // alu_result_unit

// >>> rtl/mcu_alu_instr_subset.sv
// Execution stage for the instruction subset with accumulator, status and watchdog state.
//
// The implementer's own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module mcu_alu_instr_subset #(
    parameter int WIDTH = alu_subset_pkg::DATA_WIDTH,
    parameter int ADDR_W = alu_subset_pkg::ADDR_WIDTH
) (
    // Clock, reset and enable.
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    // Instruction from the decoder.
    input wire logic issue_i,
    input wire alu_subset_pkg::op_type op_i,
    input wire logic [WIDTH-1:0] literal_i,
    input wire logic [ADDR_W-1:0] file_addr_i,
    input wire logic dest_sel_i,
    // File register read data for the addressed location.
    input wire logic [WIDTH-1:0] file_rdata_i,
    // Wake event and watchdog tick from the core.
    input wire logic wake_i,
    input wire logic wdt_tick_i,
    // Register access port.
    input wire logic [2:0] reg_addr_i,
    input wire logic [WIDTH-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [WIDTH-1:0] reg_rdata_o,
    // File register write back.
    output logic file_we_o,
    output logic [ADDR_W-1:0] file_waddr_o,
    output logic [WIDTH-1:0] file_wdata_o,
    // State outputs.
    output logic [WIDTH-1:0] acc_o,
    output logic [4:0] status_o,
    output logic [WIDTH-1:0] wdt_count_o,
    output logic sleep_o,
    output logic osc_stop_o
);
    localparam logic [2:0] REG_ACC = 3'h0;
    localparam logic [2:0] REG_STATUS = 3'h1;
    localparam logic [2:0] REG_WDT = 3'h2;

    logic [WIDTH-1:0] acc_reg;
    logic [4:0] status_reg;
    logic [WIDTH-1:0] wdt_reg;
    logic [WIDTH-1:0] prescale_reg;
    alu_subset_pkg::power_state_type state_reg;
    logic [WIDTH-1:0] result;
    logic res_carry, res_half, res_zero, we_carry, we_half, we_zero;
    logic run_op, halt_op, to_file;

    alu_result_unit #(.WIDTH(WIDTH)) result_unit (
        .op_i(op_i),
        .acc_i(acc_reg),
        .file_i(file_rdata_i),
        .literal_i(literal_i),
        .carry_i(status_reg[alu_subset_pkg::STATUS_CARRY_BIT]),
        .result_o(result),
        .carry_o(res_carry),
        .half_o(res_half),
        .zero_o(res_zero),
        .carry_we_o(we_carry),
        .half_we_o(we_half),
        .zero_we_o(we_zero)
    );

    // Instructions execute only while running; the sleep state ignores issue.
    assign run_op = clk_en_i && issue_i && (state_reg == alu_subset_pkg::ST_RUN);
    assign halt_op = run_op && (op_i == alu_subset_pkg::OP_HALT);
    assign to_file = (dest_sel_i == alu_subset_pkg::DEST_FILE) &&
        (op_i == alu_subset_pkg::OP_ROTATE_RIGHT_CARRY || op_i == alu_subset_pkg::OP_FILE_MINUS_ACC ||
         op_i == alu_subset_pkg::OP_NIBBLE_EXCHANGE || op_i == alu_subset_pkg::OP_XOR_FILE_ACC); // [RL7]

    // Accumulator update.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            acc_reg <= alu_subset_pkg::ACC_RESET;
        end else if (run_op && !halt_op && op_i != alu_subset_pkg::OP_NONE && !to_file) begin
            acc_reg <= result; // [RL7] [RL4] [RL9]
        end else if (clk_en_i && reg_wr_i && reg_addr_i == REG_ACC) begin
            acc_reg <= reg_wdata_i;
        end
    end

    // File register write back.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            file_we_o <= 1'b0;
            file_waddr_o <= '0;
            file_wdata_o <= '0;
        end else if (clk_en_i) begin
            file_we_o <= run_op && to_file; // [RL7]
            file_waddr_o <= file_addr_i;
            file_wdata_o <= result;
        end
    end

    // Status flags.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            status_reg <= alu_subset_pkg::STATUS_RESET;
        end else if (halt_op) begin
            status_reg[alu_subset_pkg::STATUS_POWER_DOWN_BIT] <= 1'b0; // [RL2]
            status_reg[alu_subset_pkg::STATUS_EXPIRY_BIT] <= 1'b1; // [RL2]
        end else if (run_op) begin
            if (we_carry) begin
                status_reg[alu_subset_pkg::STATUS_CARRY_BIT] <= res_carry; // [RL5] [RL6]
            end
            if (we_half) begin
                status_reg[alu_subset_pkg::STATUS_HALF_BIT] <= res_half; // [RL4] [RL6]
            end
            if (we_zero) begin
                status_reg[alu_subset_pkg::STATUS_ZERO_BIT] <= res_zero; // [RL11]
            end
        end else if (clk_en_i && reg_wr_i && reg_addr_i == REG_STATUS) begin
            status_reg[2:0] <= reg_wdata_i[2:0];
        end
    end

    // Watchdog counter and prescaler.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            wdt_reg <= alu_subset_pkg::WDT_CLEAR_VALUE;
            prescale_reg <= alu_subset_pkg::PRESCALE_CLEAR_VALUE;
        end else if (halt_op) begin
            wdt_reg <= alu_subset_pkg::WDT_CLEAR_VALUE; // [RL1]
            prescale_reg <= alu_subset_pkg::PRESCALE_CLEAR_VALUE; // [RL1]
        end else if (clk_en_i && wdt_tick_i) begin
            prescale_reg <= prescale_reg + 8'h01;
            if (prescale_reg == 8'hff) begin
                wdt_reg <= wdt_reg + 8'h01;
            end
        end
    end

    // Power state.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            state_reg <= alu_subset_pkg::ST_RUN;
        end else if (clk_en_i) begin
            unique case (state_reg)
                alu_subset_pkg::ST_RUN: begin
                    if (halt_op) begin
                        state_reg <= alu_subset_pkg::ST_SLEEP; // [RL3]
                    end
                end
                alu_subset_pkg::ST_SLEEP: begin
                    if (wake_i) begin
                        state_reg <= alu_subset_pkg::ST_RUN;
                    end
                end
                default: begin
                    state_reg <= alu_subset_pkg::ST_RUN;
                end
            endcase
        end
    end

    // Register read data, one cycle after the strobe.
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= '0;
        end else if (clk_en_i && reg_rd_i) begin
            unique case (reg_addr_i)
                REG_ACC: reg_rdata_o <= acc_reg;
                REG_STATUS: reg_rdata_o <= {3'h0, status_reg};
                REG_WDT: reg_rdata_o <= wdt_reg;
                default: reg_rdata_o <= '0;
            endcase
        end
    end

    assign acc_o = acc_reg;
    assign status_o = status_reg;
    assign wdt_count_o = wdt_reg;
    assign sleep_o = (state_reg == alu_subset_pkg::ST_SLEEP);
    assign osc_stop_o = (state_reg == alu_subset_pkg::ST_SLEEP); // [RL3]
endmodule // mcu_alu_instr_subset

// >>> testbench/alu_subset_checker.sv
// Assertions on the ports of the instruction-subset datapath.
`timescale 1ns/1ps
module alu_subset_checker (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic clk_en_i,
    input wire logic issue_i,
    input wire alu_subset_pkg::op_type op_i,
    input wire logic [7:0] literal_i,
    input wire logic dest_sel_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic file_we_o,
    input wire logic [7:0] file_wdata_o,
    input wire logic [7:0] acc_o,
    input wire logic [4:0] status_o,
    input wire logic [7:0] wdt_count_o,
    input wire logic sleep_o,
    input wire logic osc_stop_o
);
    logic go, halt, lsub, rot, fsub, swp, xlit;
    assign go = clk_en_i && issue_i && !sleep_o;
    assign halt = go && op_i == alu_subset_pkg::OP_HALT;
    assign lsub = go && op_i == alu_subset_pkg::OP_LIT_MINUS_ACC;
    assign rot = go && op_i == alu_subset_pkg::OP_ROTATE_RIGHT_CARRY;
    assign fsub = go && op_i == alu_subset_pkg::OP_FILE_MINUS_ACC;
    assign swp = go && op_i == alu_subset_pkg::OP_NIBBLE_EXCHANGE;
    assign xlit = go && op_i == alu_subset_pkg::OP_XOR_LIT_ACC;
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_halt_wdt:
        assert property (halt |=> wdt_count_o == 8'h00) else $error("watchdog kept");
    chk_halt_flags:
        assert property (halt |=> status_o[4:3] == 2'h2 && $stable(status_o[2:0])) else $error("halt flags");
    chk_halt_sleep:
        assert property (halt |=> sleep_o && osc_stop_o) else $error("no sleep");
    chk_lit_sub:
        assert property (lsub |=> acc_o == $past(literal_i) - $past(acc_o)
            && status_o[0] == ($past(literal_i) >= $past(acc_o)) && status_o[2] == (acc_o == 8'h00))
        else $error("literal subtract");
    chk_rot_carry:
        assert property (rot && dest_sel_i |=> file_we_o && status_o[0] == $past(file_rdata_i[0])
            && file_wdata_o == {$past(status_o[0]), $past(file_rdata_i[7:1])}) else $error("rotate");
    chk_file_sub:
        assert property (fsub && !dest_sel_i |=> !file_we_o && acc_o == $past(file_rdata_i) - $past(acc_o))
        else $error("file subtract");
    chk_swap_flags:
        assert property (swp |=> $stable(status_o)) else $error("swap flags");
    chk_xor_lit:
        assert property (xlit |=> acc_o == ($past(literal_i) ^ $past(acc_o)) && $stable(status_o[1:0])
            && status_o[2] == (acc_o == 8'h00)) else $error("literal xor");
endmodule // alu_subset_checker
bind mcu_alu_instr_subset alu_subset_checker chk (.clock_i, .rst_n_i, .clk_en_i, .issue_i, .op_i, .literal_i,
    .dest_sel_i, .file_rdata_i, .file_we_o, .file_wdata_o, .acc_o, .status_o, .wdt_count_o, .sleep_o, .osc_stop_o);

// >>> testbench/file_reg_model.sv
// Behavioural file register array at the far side of the datapath.
`timescale 1ns/1ps
module file_reg_model (
    input wire logic clock_i,
    input wire logic [6:0] raddr_i,
    input wire logic we_i,
    input wire logic [6:0] waddr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [128];
    initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37);
    assign rdata_o = mem[raddr_i];
    always @(posedge clock_i) if (we_i) mem[waddr_i] <= wdata_i;
endmodule // file_reg_model

// >>> testbench/testbench.sv
// Self-checking testbench for the instruction-subset datapath.
`timescale 1ns/1ps
module testbench;
    logic clock_i = 1'h0, rst_n_i = 1'h0, issue_i = 1'h0, dest_sel_i = 1'h0, wake_i = 1'h0, slp = 1'h0;
    logic wdt_tick_i = 1'h0, reg_wr_i = 1'h0, reg_rd_i = 1'h0, rd_d = 1'h0, file_we_o, sleep_o, osc_stop_o;
    logic clk_en_i = 1'h1;
    logic [14:0] fe, fq [$];
    alu_subset_pkg::op_type op_i = alu_subset_pkg::OP_NONE;
    logic [7:0] literal_i = 8'h00, reg_wdata_i = 8'h00, file_rdata_i, reg_rdata_o, file_wdata_o, acc_o, wdt_count_o;
    logic [7:0] acc_m, v, mem_m [128], q [$];
    logic [6:0] file_addr_i = 7'h00, file_waddr_o;
    logic [2:0] reg_addr_i = 3'h0;
    logic [4:0] status_o, st_m;
    integer seed = 93410, error_cnt = 0, n_checks = 0;
    mcu_alu_instr_subset DUT (.clock_i, .rst_n_i, .clk_en_i, .issue_i, .op_i, .literal_i, .file_addr_i,
        .dest_sel_i, .file_rdata_i, .wake_i, .wdt_tick_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .file_we_o, .file_waddr_o, .file_wdata_o, .acc_o, .status_o, .wdt_count_o, .sleep_o,
        .osc_stop_o);
    file_reg_model far_end (.clock_i, .raddr_i(file_addr_i), .we_i(file_we_o), .waddr_i(file_waddr_o),
        .wdata_i(file_wdata_o), .rdata_o(file_rdata_i));
    initial forever #20 clock_i = ~clock_i;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock_i);
        reg_wr_i <= 1'h1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge clock_i);
        reg_wr_i <= 1'h0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clock_i);
        reg_rd_i <= 1'h1;
        reg_addr_i <= a;
        q.push_back(e);
        @(posedge clock_i);
        reg_rd_i <= 1'h0;
    endtask
    task automatic tk(input int n);
        wdt_tick_i <= 1'h1;
        repeat (n) @(posedge clock_i);
        wdt_tick_i <= 1'h0;
    endtask
    task automatic run(input alu_subset_pkg::op_type o, input logic [7:0] l, input logic [6:0] a, input logic d);
        logic [7:0] f, s, r;
        f = mem_m[a];
        s = (o == alu_subset_pkg::OP_LIT_MINUS_ACC || o == alu_subset_pkg::OP_XOR_LIT_ACC) ? l : f;
        r = acc_m;
        if (!slp) begin
            case (o)
                alu_subset_pkg::OP_HALT: slp = 1'h1;
                alu_subset_pkg::OP_LIT_MINUS_ACC, alu_subset_pkg::OP_FILE_MINUS_ACC: begin
                    r = s - acc_m;
                    st_m[1:0] = {s[3:0] >= acc_m[3:0], s >= acc_m};
                end
                alu_subset_pkg::OP_ROTATE_RIGHT_CARRY: begin
                    r = {st_m[0], f[7:1]};
                    st_m[0] = f[0];
                end
                alu_subset_pkg::OP_NIBBLE_EXCHANGE: r = {f[3:0], f[7:4]};
                default: r = s ^ acc_m;
            endcase
            if (o == alu_subset_pkg::OP_HALT) st_m[4:3] = 2'h2;
            if (o inside {3'h2, 3'h4, 3'h6, 3'h7}) st_m[2] = (r == 8'h00);
            if (d && o inside {3'h3, 3'h4, 3'h5, 3'h7}) begin
                mem_m[a] = r;
                fq.push_back({a, r});
            end else acc_m = r;
        end
        @(posedge clock_i);
        issue_i <= 1'h1;
        op_i <= o;
        literal_i <= l;
        file_addr_i <= a;
        dest_sel_i <= d;
        @(posedge clock_i);
        issue_i <= 1'h0;
    endtask
    always @(posedge clock_i) begin
        rd_d <= reg_rd_i;
        if (rd_d) check(reg_rdata_o, q.pop_front());
        if (file_we_o) begin
            fe = fq.pop_front();
            check({1'h0, file_waddr_o}, {1'h0, fe[14:8]});
            check(file_wdata_o, fe[7:0]);
        end
    end
    initial begin
        st_m = 5'h18;
        acc_m = 8'h00;
        for (int i = 0; i < 128; i++) mem_m[i] = 8'(i * 37);
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'h1;
        rd(3'h1, 8'h18);
        rd(3'h5, 8'h00);
        for (int k = 0; k < 60; k++) begin
            v = 8'($random(seed));
            wr(3'h0, v);
            acc_m = v;
            wr(3'h1, v);
            st_m[2:0] = v[2:0];
            run(alu_subset_pkg::op_type'(2 + k % 6), k % 7 == 0 ? v : 8'($random(seed)),
                7'($random(seed)) | 7'h7c, v[3]);
            rd(3'h0, acc_m);
            rd(3'h1, {3'h0, st_m});
        end
        tk(300);
        rd(3'h2, 8'h01);
        run(alu_subset_pkg::OP_HALT, 8'h00, 7'h00, 1'h1);
        rd(3'h2, 8'h00);
        rd(3'h1, {3'h0, st_m});
        check({6'h00, sleep_o, osc_stop_o}, 8'h03);
        run(alu_subset_pkg::OP_XOR_LIT_ACC, 8'h3c, 7'h00, 1'h0);
        rd(3'h0, acc_m);
        wake_i <= 1'h1;
        @(posedge clock_i);
        wake_i <= 1'h0;
        slp = 1'h0;
        tk(255);
        rd(3'h2, 8'h00);
        tk(1);
        rd(3'h2, 8'h01);
        clk_en_i <= 1'h0;
        slp = 1'h1;
        run(alu_subset_pkg::OP_XOR_FILE_ACC, 8'h00, 7'h7f, 1'h1);
        clk_en_i <= 1'h1;
        slp = 1'h0;
        rd(3'h0, acc_m);
        repeat (2) @(posedge clock_i);
        check(8'(q.size() + fq.size()), 8'h00);
        report_and_stop();
    end
endmodule // testbench
